/* File: design/wwrf_defines.vh */
`ifndef WWRF_DEFINES_VH
`define WWRF_DEFINES_VH

// Register word indices, byte address is four times these
`define WWRF_IDX_FLAGS       3'h0
`define WWRF_IDX_CTRL_PERIOD 3'h1
`define WWRF_IDX_CTRL_CLKWIN 3'h2
`define WWRF_IDX_PSC_LOW     3'h3
`define WWRF_IDX_PSC_HIGH    3'h4
`define WWRF_IDX_TIMER       3'h5

// Cause flag bit positions
`define WWRF_FLAG_STACK_OVERFLOW_FLAG 7
`define WWRF_FLAG_STACK_UNDERFLOW_FLAG 6
`define WWRF_FLAG_WV     5
`define WWRF_FLAG_WDT    4
`define WWRF_FLAG_PIN    3
`define WWRF_FLAG_RI     2
`define WWRF_FLAG_POR    1
`define WWRF_FLAG_BOR    0

// Flag image loaded by power-on reset
`define WWRF_FLAGS_POR 8'h3C

// Control field positions
`define WWRF_PS_LSB  1
`define WWRF_PS_MSB  5
`define WWRF_SEN_BIT 0
`define WWRF_CS_LSB  4
`define WWRF_CS_MSB  6
`define WWRF_WIN_LSB 0
`define WWRF_WIN_MSB 2

// Configuration codes and reset values
`define WWRF_PERIOD_SW     5'h1F
`define WWRF_PS_RESET_SW   5'h0B
`define WWRF_PS_MAX_CODE   5'h12
`define WWRF_CLOCK_SW      3'h7
`define WWRF_CS_RESET_SW   3'h0
`define WWRF_CS_LOW_OSC    3'h0
`define WWRF_CS_MED_OSC    3'h1
`define WWRF_WINDOW_SW     3'h7
`define WWRF_WINDOW_FULL   3'h7
`define WWRF_WCTR_LAST     5'h1F

// Operating modes
`define WWRF_MODE_ON       2'h3
`define WWRF_MODE_SLEEPOFF 2'h2
`define WWRF_MODE_SW       2'h1

`endif

/* File: design/wwrf_sync.v */
`default_nettype none

module wwrf_sync
#(
  parameter WIDTH = 2
)
(
  // Clock and reset
  input  wire             clk_in,
  input  wire             reset_in,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // Two flip-flop synchroniser
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // wwrf_sync

`default_nettype wire

/* File: design/wwrf_top.v */
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
`include "wwrf_defines.vh"

module wwrf_top
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // Avalon-MM slave
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // Watchdog oscillators
  input  wire        low_freq_oscillator_in,
  input  wire        medium_freq_oscillator_in,
  // Configuration word fields
  input  wire [1:0]  config_mode_field_in,
  input  wire [4:0]  config_period_field_in,
  input  wire [2:0]  config_clock_field_in,
  input  wire [2:0]  config_window_field_in,
  // Core events
  input  wire        watchdog_clear_instruction_in,
  input  wire        sleep_in,
  // Reset causes, valid while reset_in is high
  input  wire        por_cause_in,
  input  wire        bor_cause_in,
  input  wire        pin_reset_cause_in,
  input  wire        reset_instr_cause_in,
  input  wire        stack_overflow_cause_in,
  input  wire        stack_underflow_cause_in,
  // Watchdog results
  output reg         wdt_reset_req_out,
  output reg         wdt_wake_out
);

  // Software visible state
  reg  [7:0]  reset_cause_flags;
  reg  [4:0]  prescale_select;
  reg         software_enable_bit;
  reg  [2:0]  clock_select;
  reg  [2:0]  window_size;
  // Counters and arming
  reg  [17:0] prescale_counter;
  reg  [4:0]  window_counter;
  reg         armed;
  // Pending causes carried into the reset
  reg         pend_timeout;
  reg         pend_violation;
  // Edge history
  reg         osc_prev;
  reg         sleep_prev;

  wire [1:0]  osc_sync;
  wire        osc_sel;
  wire        wdt_tick;
  wire        run;
  wire        windowed;
  wire        window_open;
  wire [4:0]  ps_eff;
  wire [17:0] psc_max;
  wire        expire;
  wire        bus_req;
  wire        bus_take;
  wire        bus_done;
  wire [2:0]  reg_idx;
  wire        wr_lane;
  wire        wr_ctrl;
  wire        clr_bad;
  wire        clear_cnt;
  reg  [7:0]  rd_byte;

  // Oscillator pins pass two flip-flops
  wwrf_sync #(
    .WIDTH (2)
  ) u_osc_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({medium_freq_oscillator_in, low_freq_oscillator_in}),
    .sync_out (osc_sync)
  );

  assign osc_sel  = (clock_select == `WWRF_CS_LOW_OSC) ? osc_sync[0] :
                    (clock_select == `WWRF_CS_MED_OSC) ? osc_sync[1] : 1'b0;
  assign wdt_tick = osc_sel & ~osc_prev;

  // enable bit only in mode 01
  assign run = (config_mode_field_in == `WWRF_MODE_ON) |
               ((config_mode_field_in == `WWRF_MODE_SLEEPOFF) & ~sleep_in) |
               ((config_mode_field_in == `WWRF_MODE_SW) & software_enable_bit);

  // reserved codes fall back to 1:32
  assign ps_eff  = (prescale_select > `WWRF_PS_MAX_CODE) ? 5'h00 : prescale_select;
  assign psc_max = (18'h0_0001 << ps_eff) - 18'h0_0001;

  // expiry when the full ratio is counted
  assign expire = run & wdt_tick & (prescale_counter == psc_max) &
                  (window_counter == `WWRF_WCTR_LAST);

  // closed share is seven minus code eighths
  // window test on the five timer bits
  assign windowed    = (window_size != `WWRF_WINDOW_FULL);
  assign window_open = (window_counter >= {~window_size, 2'b00});

  // Bus decode
  assign bus_req  = avs_read_in | avs_write_in;
  assign bus_take = bus_req & avs_waitrequest_out;
  assign bus_done = bus_req & ~avs_waitrequest_out;
  assign reg_idx  = avs_address_in[4:2];
  assign wr_lane  = bus_done & avs_write_in & avs_byteenable_in[0];
  assign wr_ctrl  = wr_lane & ((reg_idx == `WWRF_IDX_CTRL_PERIOD) |
                               (reg_idx == `WWRF_IDX_CTRL_CLKWIN));

  // in windowed mode, clear while unarmed is a violation
  // clear outside the open window is a violation
  assign clr_bad = watchdog_clear_instruction_in & run & windowed &
                   (~armed | ~window_open);

  // Counter clearing events
  assign clear_cnt = ~run | (sleep_in != sleep_prev) | wr_ctrl |
                     (watchdog_clear_instruction_in & ~clr_bad);

  // Read multiplexer
  always @*
  begin
    case (reg_idx)
      `WWRF_IDX_FLAGS:       rd_byte = reset_cause_flags;
      `WWRF_IDX_CTRL_PERIOD: rd_byte = {2'b00, prescale_select, software_enable_bit};
      `WWRF_IDX_CTRL_CLKWIN: rd_byte = {1'b0, clock_select, 1'b0, window_size};
      `WWRF_IDX_PSC_LOW:     rd_byte = prescale_counter[7:0];
      `WWRF_IDX_PSC_HIGH:    rd_byte = prescale_counter[15:8];
      `WWRF_IDX_TIMER:       rd_byte = {window_counter, armed, prescale_counter[17:16]};
      default:               rd_byte = 8'h00;
    endcase
  end

  // Bus slave handshake, one wait cycle per access
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_out <= ~bus_take;
      if (bus_take & avs_read_in)
        avs_readdata_out <= {24'h00_0000, rd_byte};
    end
  end

  // Reset cause flags
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      if (por_cause_in)
        reset_cause_flags <= `WWRF_FLAGS_POR;
      else if (bor_cause_in)
        reset_cause_flags <= {6'b00_1111, reset_cause_flags[`WWRF_FLAG_POR], 1'b0};
      else
      begin
        if (pin_reset_cause_in)
          reset_cause_flags[`WWRF_FLAG_PIN] <= 1'b0;
        if (reset_instr_cause_in)
          reset_cause_flags[`WWRF_FLAG_RI] <= 1'b0;
        if (stack_overflow_cause_in)
          reset_cause_flags[`WWRF_FLAG_STACK_OVERFLOW_FLAG] <= 1'b1;
        if (stack_underflow_cause_in)
          reset_cause_flags[`WWRF_FLAG_STACK_UNDERFLOW_FLAG] <= 1'b1;
        if (pend_timeout)
          reset_cause_flags[`WWRF_FLAG_WDT] <= 1'b0;
        if (pend_violation)
          reset_cause_flags[`WWRF_FLAG_WV] <= 1'b0;
      end
    end
    // software value stored, no reset action
    else if (wr_lane & (reg_idx == `WWRF_IDX_FLAGS))
      reset_cause_flags <= avs_writedata_in[7:0];
  end

  // Control registers
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      if (config_period_field_in == `WWRF_PERIOD_SW)
        prescale_select <= `WWRF_PS_RESET_SW;
      else
        prescale_select <= config_period_field_in;
      software_enable_bit <= 1'b0;
      if (config_clock_field_in == `WWRF_CLOCK_SW)
        clock_select <= `WWRF_CS_RESET_SW;
      else
        clock_select <= config_clock_field_in;
      window_size <= config_window_field_in;
    end
    else if (wr_lane & (reg_idx == `WWRF_IDX_CTRL_PERIOD))
    begin
      software_enable_bit <= avs_writedata_in[`WWRF_SEN_BIT];
      // prescale writable only in software period mode
      if (config_period_field_in == `WWRF_PERIOD_SW)
        prescale_select <= avs_writedata_in[`WWRF_PS_MSB:`WWRF_PS_LSB];
    end
    else if (wr_lane & (reg_idx == `WWRF_IDX_CTRL_CLKWIN))
    begin
      if (config_clock_field_in == `WWRF_CLOCK_SW)
        clock_select <= avs_writedata_in[`WWRF_CS_MSB:`WWRF_CS_LSB];
      if (config_window_field_in == `WWRF_WINDOW_SW)
        window_size <= avs_writedata_in[`WWRF_WIN_MSB:`WWRF_WIN_LSB];
    end
  end

  // Watchdog counters, arming and reset request
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prescale_counter  <= 18'h0_0000;
      window_counter    <= 5'h00;
      armed             <= 1'b0;
      osc_prev          <= 1'b0;
      sleep_prev        <= 1'b0;
      wdt_reset_req_out <= 1'b0;
      wdt_wake_out      <= 1'b0;
      if (por_cause_in)
      begin
        pend_timeout   <= 1'b0;
        pend_violation <= 1'b0;
      end
    end
    else
    begin
      osc_prev     <= osc_sel;
      sleep_prev   <= sleep_in;
      wdt_wake_out <= 1'b0;
      if (~wdt_reset_req_out)
      begin
        pend_timeout   <= 1'b0;
        pend_violation <= 1'b0;
      end
      if (wdt_reset_req_out)
      begin
        // Frozen until the system reset arrives
        prescale_counter <= prescale_counter;
      end
      else if (clr_bad)
      begin
        wdt_reset_req_out <= 1'b1;
        pend_violation    <= 1'b1;
      end
      else if (clear_cnt)
      begin
        prescale_counter <= 18'h0_0000;
        window_counter   <= 5'h00;
        armed            <= 1'b0;
      end
      else if (expire)
      begin
        prescale_counter <= 18'h0_0000;
        window_counter   <= 5'h00;
        armed            <= 1'b0;
        // timeout requests reset, or wakes from sleep
        if (sleep_in)
          wdt_wake_out <= 1'b1;
        else
        begin
          wdt_reset_req_out <= 1'b1;
          pend_timeout      <= 1'b1;
        end
      end
      else
      begin
        // one prescale step per watchdog clock
        if (run & wdt_tick)
        begin
          if (prescale_counter == psc_max)
          begin
            prescale_counter <= 18'h0_0000;
            window_counter   <= window_counter + 5'h01;
          end
          else
            prescale_counter <= prescale_counter + 18'h0_0001;
        end
        if (bus_done & avs_read_in & (reg_idx == `WWRF_IDX_CTRL_PERIOD) & windowed)
          armed <= 1'b1;
      end
    end
  end

endmodule // wwrf_top

`default_nettype wire

/* File: sim/wwrf_checker.sv */
`default_nettype none

module wwrf_checker
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // Register bus
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Watchdog
  input wire logic [1:0]  config_mode_field_in,
  input wire logic        sleep_in,
  input wire logic        wdt_reset_req_out,
  input wire logic        wdt_wake_out
);
  // One clock, reset masks everything
  default clocking dck @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("late answer");
  property p_wait_single;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("long answer");
  property p_rd_stable;
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_req_hold;
    wdt_reset_req_out |=> wdt_reset_req_out;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_req_clear;
    $fell(reset_in) |-> !wdt_reset_req_out;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request after reset");
  property p_wake_pulse;
    wdt_wake_out |=> !wdt_wake_out;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("long wake");
  property p_off_mode;
    config_mode_field_in == 2'h0 |-> !wdt_reset_req_out && !wdt_wake_out;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off mode acted");
  property p_sleep_off;
    config_mode_field_in == 2'h2 && sleep_in |=> !$rose(wdt_reset_req_out) && !wdt_wake_out;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("acted in sleep");

  // Main scenarios
  c_expire: cover property ($rose(wdt_reset_req_out));
  c_wake: cover property ($rose(wdt_wake_out));
  c_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule // wwrf_checker

bind wwrf_top wwrf_checker u_chk
(
  .clk_in(clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .config_mode_field_in(config_mode_field_in),
  .sleep_in(sleep_in), .wdt_reset_req_out(wdt_reset_req_out), .wdt_wake_out(wdt_wake_out)
);

`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none

`define CHK(g, x) \
  begin \
    checks_done++; \
    if ((g) !== (x)) \
    begin \
      bad_count++; \
      $display("ERROR %0t got %h exp %h", $time, g, x); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and observed outputs
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        wait_rq;
  logic        lf = 1'b0;
  logic        mf = 1'b0;
  logic [1:0]  mode = 2'h3;
  logic [4:0]  per = 5'h1F;
  logic [2:0]  ccfg = 3'h7;
  logic [2:0]  wcfg = 3'h7;
  logic        clr = 1'b0;
  logic        slp = 1'b0;
  logic [5:0]  cause = 6'h01;
  logic        req;
  logic        wake;
  // Bookkeeping and case tables
  int          bad_count = 0;
  int          checks_done = 0;
  int          wakes = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [7:0]  r;
  logic [14:0] c;
  logic [7:0]  rv [7] = '{8'h3C, 8'h16, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [5:0]  kv [6] = '{6'h04, 6'h08, 6'h10, 6'h20, 6'h02, 6'h00};
  logic [14:0] tc [7] = '{15'h7001, 15'h5000, 15'h0000, 15'h2000, 15'h29CE, 15'h6200, 15'h6004};

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  wwrf_top u_dut
  (
    .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq),
    .low_freq_oscillator_in(lf), .medium_freq_oscillator_in(mf),
    .config_mode_field_in(mode), .config_period_field_in(per),
    .config_clock_field_in(ccfg), .config_window_field_in(wcfg),
    .watchdog_clear_instruction_in(clr), .sleep_in(slp),
    .por_cause_in(cause[0]), .bor_cause_in(cause[1]), .pin_reset_cause_in(cause[2]),
    .reset_instr_cause_in(cause[3]), .stack_overflow_cause_in(cause[4]),
    .stack_underflow_cause_in(cause[5]), .wdt_reset_req_out(req), .wdt_wake_out(wake)
  );

  // Read results against the oldest note, wake pulses counted
  always @(posedge clk_in)
  begin
    if (rd && wait_rq === 1'b0)
    begin
      e = exp_q.pop_front();
      `CHK(rdat & {24'hFF_FFFF, e[15:8]}, {24'h00_0000, e[7:0] & e[15:8]})
    end
    if (wake === 1'b1)
      wakes++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One bus access, read expectation noted with its mask
  task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d, input logic [7:0] m);
    int n;
    n = 0;
    adr <= {i, 2'b00};
    wdat <= {24'h00_0000, d};
    wr <= w;
    rd <= ~w;
    if (!w)
      exp_q.push_back({m, d});
    @(posedge clk_in);
    while (wait_rq !== 1'b0)
    begin
      if (++n > 20)
      begin
        bad_count++;
        results();
      end
      @(posedge clk_in);
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
  endtask

  // Oscillator edges, then settle time for the synchroniser
  task automatic ticks(input int n, input logic s);
    repeat (n)
    begin
      lf <= ~s;
      mf <= s;
      repeat (4) @(posedge clk_in);
      lf <= 1'b0;
      mf <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (8) @(posedge clk_in);
  endtask

  task automatic rst(input logic [1:0] m, input logic [4:0] p, input logic [2:0] k,
                     input logic [2:0] w, input logic [5:0] q);
    reset_in <= 1'b1;
    mode <= m;
    per <= p;
    ccfg <= k;
    wcfg <= w;
    cause <= q;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    cause <= 6'h00;
    @(posedge clk_in);
  endtask

  initial
  begin
    void'($urandom(32'hEC17_D130));
    rst(2'h3, 5'h1F, 3'h7, 3'h7, 6'h01);
    for (int i = 0; i < 7; i++)
      bus(1'b0, 3'(i), rv[i], 8'hFF);
    r = 8'($urandom());
    bus(1'b1, 3'h1, r, 8'h00);
    bus(1'b0, 3'h1, r & 8'h3F, 8'hFF);
    bus(1'b1, 3'h2, r, 8'h00);
    bus(1'b0, 3'h2, r & 8'h77, 8'hFF);
    bus(1'b1, 3'h7, r, 8'h00);
    bus(1'b0, 3'h7, 8'h00, 8'hFF);
    rst(2'h3, 5'h05, 3'h0, 3'h2, 6'h00);
    bus(1'b1, 3'h1, 8'hFF, 8'h00);
    bus(1'b0, 3'h1, 8'h0B, 8'hFF);
    bus(1'b1, 3'h2, 8'h75, 8'h00);
    bus(1'b0, 3'h2, 8'h02, 8'hFF);
    $display("done registers");
    // Each reset touches only its own flag, except BOR, which reloads every flag but POR
    for (int i = 0; i < 6; i++)
    begin
      r = 8'($urandom());
      bus(1'b1, 3'h0, r, 8'h00);
      bus(1'b0, 3'h0, r, 8'hFF);
      `CHK(req, 1'b0)
      rst(2'h0, 5'h00, 3'h0, 3'h7, kv[i]);
      case (i)
        0: r[3] = 1'b0;
        1: r[2] = 1'b0;
        2: r[7] = 1'b1;
        3: r[6] = 1'b1;
        4: r = {6'h0F, r[1], 1'b0};
        default: ;
      endcase
      bus(1'b0, 3'h0, r, 8'hFF);
    end
    $display("done flags");
    // Time-out at 32 ticks, watchdog flag afterwards
    rst(2'h3, 5'h00, 3'h0, 3'h7, 6'h00);
    bus(1'b1, 3'h0, 8'hFF, 8'h00);
    ticks(31, 1'b0);
    bus(1'b0, 3'h5, 8'hF8, 8'hFF);
    `CHK(req, 1'b0)
    ticks(1, 1'b0);
    `CHK(req, 1'b1)
    rst(2'h3, 5'h00, 3'h0, 3'h7, 6'h00);
    bus(1'b0, 3'h0, 8'hEF, 8'hFF);
    $display("done timeout");
    // Half window: good clear, early clear, unarmed clear
    for (int i = 0; i < 3; i++)
    begin
      rst(2'h3, 5'h00, 3'h0, 3'h3, 6'h00);
      bus(1'b1, 3'h0, 8'hFF, 8'h00);
      if (i < 2)
      begin
        bus(1'b0, 3'h1, 8'h00, 8'h00);
        bus(1'b0, 3'h5, 8'h04, 8'h04);
      end
      ticks(i == 1 ? 5 : 20, 1'b0);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      repeat (4) @(posedge clk_in);
      `CHK(req, 1'(i != 0))
      rst(2'h3, 5'h00, 3'h0, 3'h3, 6'h00);
      bus(1'b0, 3'h0, i ? 8'hDF : 8'hFF, 8'hFF);
    end
    $display("done window");
    // Modes, sleep, clock sources and prescale codes
    for (int i = 0; i < 7; i++)
    begin
      c = tc[i];
      rst(c[14:13], c[6:2], c[10:8], 3'h7, 6'h00);
      if (c[11])
        bus(1'b1, 3'h1, 8'h01, 8'h00);
      slp <= c[12];
      wakes = 0;
      ticks(34, c[7]);
      `CHK(req, c[1])
      `CHK(wakes, int'(c[0]))
      slp <= 1'b0;
    end
    // Code 1 takes two ticks per window step, prescale byte visible
    rst(2'h3, 5'h01, 3'h0, 3'h7, 6'h00);
    ticks(3, 1'b0);
    bus(1'b0, 3'h3, 8'h01, 8'hFF);
    bus(1'b0, 3'h5, 8'h08, 8'hFF);
    $display("done modes");
    results();
  end
endmodule // tb_top

`default_nettype wire
